// [include/cpc_pkg.sv]
// Constants, types and helper functions of the compare pulse and PWM channel
package cpc_pkg;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] CPC_CTRL_OFF = 8'h00;
   localparam logic [7:0] CPC_PRI_OFF = 8'h04;
   localparam logic [7:0] CPC_SEC_OFF = 8'h08;
   localparam logic [7:0] CPC_FLAG_OFF = 8'h0c;
   localparam logic [7:0] CPC_T0CTL_OFF = 8'h10;
   localparam logic [7:0] CPC_T0PER_OFF = 8'h14;
   localparam logic [7:0] CPC_T0CNT_OFF = 8'h18;
   localparam logic [7:0] CPC_T1CTL_OFF = 8'h1c;
   localparam logic [7:0] CPC_T1PER_OFF = 8'h20;
   localparam logic [7:0] CPC_T1CNT_OFF = 8'h24;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CPC_ON_BIT = 15;
   localparam int CPC_WIDE_BIT = 5;
   localparam int CPC_FLT_BIT = 4;
   localparam int CPC_TSEL_BIT = 3;
   localparam int CPC_MODE_LSB = 0;
   localparam int CPC_FLAG_BIT = 0;
   localparam int CPC_TON_BIT = 15;
   localparam int CPC_TPS_LSB = 4;
   localparam int CPC_TWIDE_BIT = 3;

   // ------------------------------------------------------------
   // Codes and reset values
   // ------------------------------------------------------------
   localparam logic [2:0] CPC_MODE_CONT = 3'h5;
   localparam logic [2:0] CPC_MODE_PWM = 3'h6;
   localparam logic [2:0] CPC_MODE_PWMF = 3'h7;
   localparam logic [1:0] CPC_RESP_OKAY = 2'h0;
   localparam logic [1:0] CPC_RESP_SLVERR = 2'h2;
   localparam logic [31:0] CPC_REG_RST = 32'h0;
   localparam logic [2:0] CPC_DIV_RST = 3'h0;
   localparam int CPC_FAULT_A_LAST = 4;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_CONT = 2'b01,
      PH_PWM = 2'b10,
      PH_FAULT = 2'b11
   } cpc_phase_e;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] cpc_mask(input logic [31:0] v, input logic wide);
      cpc_mask = wide ? v : {16'h0, v[15:0]};
   endfunction

   function automatic logic cpc_eq(input logic [31:0] a, input logic [31:0] b,
                                   input logic wide);
      cpc_eq = (cpc_mask(a, wide) == cpc_mask(b, wide));
   endfunction

   function automatic logic cpc_lt(input logic [31:0] a, input logic [31:0] b,
                                   input logic wide);
      cpc_lt = (cpc_mask(a, wide) < cpc_mask(b, wide));
   endfunction

   function automatic logic [31:0] cpc_merge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
      cpc_merge = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            cpc_merge[i*8 +: 8] = data[i*8 +: 8];
         end
      end
   endfunction

endpackage

// [rtl/cpc_timebase.sv]
// Free-running time base with prescaler and period wrap
module cpc_timebase
   import cpc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Settings
   input wire logic run,
   input wire logic wide,
   input wire logic [1:0] prescale,
   input wire logic [31:0] period,
   // Count out
   output logic [31:0] count,
   output logic step,
   output logic wrap
);

   typedef struct packed {
      logic [2:0] div;
      logic [31:0] count;
      logic step;
      logic wrap;
   } cpc_tb_s;

   cpc_tb_s st_ff;
   cpc_tb_s nxt_st;
   logic [2:0] ratio_m1;

   // ------------------------------------------------------------
   // Counting
   // ------------------------------------------------------------
   // Prescale ratios are 1, 2, 4 and 8 clocks per count
   always_comb begin
      ratio_m1 = 3'((4'h1 << prescale) - 4'h1);
      nxt_st = st_ff;
      nxt_st.step = 1'b0;
      nxt_st.wrap = 1'b0;
      if (run) begin
         if (st_ff.div >= ratio_m1) begin
            nxt_st.div = CPC_DIV_RST;
            nxt_st.step = 1'b1;
            if (cpc_eq(st_ff.count, period, wide)) begin
               nxt_st.count = CPC_REG_RST;
               nxt_st.wrap = 1'b1;
            end else begin
               nxt_st.count = cpc_mask(st_ff.count + 32'h1, wide);
            end
         end else begin
            nxt_st.div = st_ff.div + 3'h1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign count = st_ff.count;
   assign step = st_ff.step;
   assign wrap = st_ff.wrap;

endmodule

// [rtl/cpc_channel.sv]
// Compare channel: continuous pulse and PWM generation with fault shutdown
// ------------------------------------------------------------
// ------------------------------------------------------------
module cpc_channel
   import cpc_pkg::*;
#(
   parameter int CHANNEL_NUM = 1
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pins
   input wire logic fault_input_a,
   input wire logic fault_input_b,
   output logic compare_output_pin,
   output logic compare_output_pin_oe,
   output logic channel_event_flag
);

   typedef struct packed {
      logic awrdy;
      logic awg;
      logic [7:0] awa;
      logic wrdy;
      logic wg;
      logic [31:0] wd;
      logic [3:0] ws;
      logic bvalid;
      logic [1:0] bresp;
      logic arrdy;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic on;
      logic wide;
      logic flt;
      logic tsel;
      logic [2:0] mode;
      logic [31:0] pri;
      logic [31:0] sec;
      logic flag;
      logic [1:0] ton;
      logic [1:0] twide;
      logic [1:0][1:0] tps;
      logic [1:0][31:0] tper;
      cpc_phase_e ph;
      logic out;
      logic oe;
      logic fs1;
      logic fs2;
   } cpc_ch_s;

   cpc_ch_s st_ff, nxt_st;

   logic [1:0][31:0] t_cnt;
   logic [1:0] t_step, t_wrap;
   logic [31:0] cnt, duty_eff, ctrl_rd, wv, rv;
   logic fault_raw, stp, wrp, hit_ok, set_ev, clr_ev, mode_wr, wr, ti;

   // ------------------------------------------------------------
   // Time bases
   // ------------------------------------------------------------
   cpc_timebase u_tb0 (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .run(st_ff.ton[0]),
      .wide(st_ff.twide[0]),
      .prescale(st_ff.tps[0]),
      .period(st_ff.tper[0]),
      .count(t_cnt[0]),
      .step(t_step[0]),
      .wrap(t_wrap[0])
   );

   cpc_timebase u_tb1 (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .run(st_ff.ton[1]),
      .wide(st_ff.twide[1]),
      .prescale(st_ff.tps[1]),
      .period(st_ff.tper[1]),
      .count(t_cnt[1]),
      .step(t_step[1]),
      .wrap(t_wrap[1])
   );

   // ------------------------------------------------------------
   // Channel and register logic
   // ------------------------------------------------------------
   // Fault pin choice is fixed by the channel number
   assign fault_raw = (CHANNEL_NUM <= CPC_FAULT_A_LAST) ? fault_input_a : fault_input_b;

   always_comb begin
      cnt = st_ff.tsel ? t_cnt[1] : t_cnt[0];
      stp = st_ff.tsel ? t_step[1] : t_step[0];
      wrp = st_ff.tsel ? t_wrap[1] : t_wrap[0];
      // On the wrap count the buffered duty already applies
      duty_eff = wrp ? st_ff.sec : st_ff.pri;
      ctrl_rd = {16'h0, st_ff.on, 9'h0, st_ff.wide, st_ff.flt, st_ff.tsel, st_ff.mode};
      nxt_st = st_ff;
      set_ev = 1'b0;
      clr_ev = 1'b0;
      mode_wr = 1'b0;
      wv = CPC_REG_RST;
      rv = CPC_REG_RST;
      hit_ok = 1'b1;
      ti = 1'b0;
      nxt_st.fs1 = !fault_raw;
      nxt_st.fs2 = st_ff.fs1;

      // Pin behaviour per phase
      case (st_ff.ph)
         PH_CONT: begin
            if (stp && cpc_eq(cnt, st_ff.sec, st_ff.wide)) begin
               nxt_st.out = 1'b0;
               set_ev = 1'b1;
            end else if (stp && cpc_eq(cnt, st_ff.pri, st_ff.wide)) begin
               nxt_st.out = 1'b1;
            end
         end
         PH_PWM: begin
            // Compare against count gives 0, 100 and one-low-count corners
            nxt_st.out = cpc_lt(cnt, duty_eff, st_ff.wide);
            if (wrp) begin
               nxt_st.pri = st_ff.sec;
            end
         end
         PH_FAULT: begin
            nxt_st.out = 1'b0;
         end
         default: begin
            nxt_st.out = 1'b0;
         end
      endcase

      // Synchroniser holds the fault level, so its reset value shows no fault
      if (st_ff.on && st_ff.mode == CPC_MODE_PWMF && st_ff.fs2 && st_ff.ph != PH_FAULT) begin
         nxt_st.ph = PH_FAULT;
         nxt_st.flt = 1'b1;
         set_ev = 1'b1;
      end

      // Write channel
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end
      if (s_axi_awvalid && st_ff.awrdy) begin
         nxt_st.awg = 1'b1;
         nxt_st.awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_ff.wrdy) begin
         nxt_st.wg = 1'b1;
         nxt_st.wd = s_axi_wdata;
         nxt_st.ws = s_axi_wstrb;
      end
      wr = st_ff.awg && st_ff.wg && !st_ff.bvalid;
      if (wr) begin
         nxt_st.awg = 1'b0;
         nxt_st.wg = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = CPC_RESP_OKAY;
         case (st_ff.awa)
            CPC_CTRL_OFF: begin
               wv = cpc_merge(ctrl_rd, st_ff.wd, st_ff.ws);
               nxt_st.on = wv[CPC_ON_BIT];
               nxt_st.wide = wv[CPC_WIDE_BIT];
               nxt_st.tsel = wv[CPC_TSEL_BIT];
               nxt_st.mode = wv[CPC_MODE_LSB +: 3];
               mode_wr = st_ff.ws[0];
            end
            CPC_PRI_OFF: begin
               // Duty is locked while a PWM code is selected
               if (st_ff.mode != CPC_MODE_PWM && st_ff.mode != CPC_MODE_PWMF) begin
                  nxt_st.pri = cpc_merge(st_ff.pri, st_ff.wd, st_ff.ws);
               end
            end
            CPC_SEC_OFF: begin
               nxt_st.sec = cpc_merge(st_ff.sec, st_ff.wd, st_ff.ws);
            end
            CPC_FLAG_OFF: begin
               clr_ev = st_ff.ws[0] && st_ff.wd[CPC_FLAG_BIT];
            end
            CPC_T0CTL_OFF, CPC_T1CTL_OFF: begin
               ti = (st_ff.awa == CPC_T1CTL_OFF);
               wv = cpc_merge(CPC_REG_RST, st_ff.wd, st_ff.ws);
               nxt_st.ton[ti] = wv[CPC_TON_BIT];
               nxt_st.twide[ti] = wv[CPC_TWIDE_BIT];
               nxt_st.tps[ti] = wv[CPC_TPS_LSB +: 2];
            end
            CPC_T0PER_OFF, CPC_T1PER_OFF: begin
               ti = (st_ff.awa == CPC_T1PER_OFF);
               nxt_st.tper[ti] = cpc_merge(st_ff.tper[ti], st_ff.wd, st_ff.ws);
            end
            CPC_T0CNT_OFF, CPC_T1CNT_OFF: begin
               nxt_st.bresp = CPC_RESP_OKAY;
            end
            default: begin
               nxt_st.bresp = CPC_RESP_SLVERR;
            end
         endcase
      end

      // Mode rewrite: leaves fault only once the input is high again
      if (mode_wr && (nxt_st.ph != PH_FAULT || !st_ff.fs2)) begin
         nxt_st.flt = 1'b0;
         case (nxt_st.mode)
            CPC_MODE_CONT: begin
               nxt_st.ph = PH_CONT;
               nxt_st.out = 1'b0;
            end
            CPC_MODE_PWM, CPC_MODE_PWMF: begin
               nxt_st.ph = PH_PWM;
            end
            default: begin
               nxt_st.ph = PH_IDLE;
               nxt_st.out = 1'b0;
            end
         endcase
      end
      nxt_st.oe = nxt_st.on && nxt_st.ph != PH_FAULT;

      // Set wins over software clear
      nxt_st.flag = (st_ff.flag && !clr_ev) || set_ev;

      // Read channel
      if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_ff.arrdy) begin
         case (s_axi_araddr)
            CPC_CTRL_OFF: rv = ctrl_rd;
            CPC_PRI_OFF: rv = st_ff.pri;
            CPC_SEC_OFF: rv = st_ff.sec;
            CPC_FLAG_OFF: rv = {31'h0, st_ff.flag};
            CPC_T0CTL_OFF: rv = {16'h0, st_ff.ton[0], 9'h0, st_ff.tps[0], st_ff.twide[0], 3'h0};
            CPC_T1CTL_OFF: rv = {16'h0, st_ff.ton[1], 9'h0, st_ff.tps[1], st_ff.twide[1], 3'h0};
            CPC_T0PER_OFF: rv = st_ff.tper[0];
            CPC_T1PER_OFF: rv = st_ff.tper[1];
            CPC_T0CNT_OFF: rv = t_cnt[0];
            CPC_T1CNT_OFF: rv = t_cnt[1];
            default: hit_ok = 1'b0;
         endcase
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata = rv;
         nxt_st.rresp = hit_ok ? CPC_RESP_OKAY : CPC_RESP_SLVERR;
      end
      nxt_st.awrdy = !nxt_st.awg;
      nxt_st.wrdy = !nxt_st.wg;
      nxt_st.arrdy = !nxt_st.rvalid;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign s_axi_awready = st_ff.awrdy;
   assign s_axi_wready = st_ff.wrdy;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_arready = st_ff.arrdy;
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.rresp;
   assign s_axi_rvalid = st_ff.rvalid;
   assign compare_output_pin = st_ff.out;
   assign channel_event_flag = st_ff.flag;
   // Raw pin gates the enable so shutdown does not wait for a clock edge
   assign compare_output_pin_oe = st_ff.oe &&
      !(st_ff.mode == CPC_MODE_PWMF && !fault_raw);

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   a_cont_entry_low: assert property (
      (wr && st_ff.awa == CPC_CTRL_OFF && st_ff.ws[0] && st_ff.ph != PH_FAULT
       && !(st_ff.on && st_ff.mode == CPC_MODE_PWMF && st_ff.fs2)
       && st_ff.wd[2:0] == CPC_MODE_CONT) |=> (st_ff.ph == PH_CONT && !compare_output_pin))
      else $error("pin not low on continuous mode entry");
   a_cont_rise: assert property (
      (st_ff.ph == PH_CONT && stp && cpc_eq(cnt, st_ff.pri, st_ff.wide)
       && !cpc_eq(cnt, st_ff.sec, st_ff.wide) && !mode_wr) |=> compare_output_pin)
      else $error("no rising edge on primary match");
   a_cont_fall: assert property (
      (st_ff.ph == PH_CONT && stp && cpc_eq(cnt, st_ff.sec, st_ff.wide))
      |=> !compare_output_pin ##0 channel_event_flag)
      else $error("no falling edge or flag on secondary match");
   a_duty_zero: assert property (
      (st_ff.ph == PH_PWM && duty_eff == CPC_REG_RST && !mode_wr) |=> !compare_output_pin)
      else $error("zero duty drove pin high");
   a_duty_full: assert property (
      (st_ff.ph == PH_PWM && cpc_lt(st_ff.tper[st_ff.tsel], duty_eff, st_ff.wide)
       && !mode_wr) |=> compare_output_pin)
      else $error("over-period duty drove pin low");
   a_duty_latch: assert property (
      (st_ff.ph == PH_PWM && wrp) |=> (st_ff.pri == $past(st_ff.sec)))
      else $error("duty not reloaded at period match");
   a_pri_locked: assert property (
      (st_ff.mode == CPC_MODE_PWM && !wrp ##1 st_ff.mode == CPC_MODE_PWM) |-> $stable(st_ff.pri))
      else $error("primary compare changed during PWM");
   a_fault_hiz: assert property (
      (st_ff.mode == CPC_MODE_PWMF && !fault_raw) |-> !compare_output_pin_oe)
      else $error("pin driven during fault");
   a_fault_status: assert property (
      (st_ff.on && st_ff.mode == CPC_MODE_PWMF && st_ff.fs2 && st_ff.ph != PH_FAULT)
      |=> (st_ff.flt && channel_event_flag && st_ff.ph == PH_FAULT))
      else $error("fault status or flag missing");
   a_off_release: assert property (
      (!st_ff.on) |-> !compare_output_pin_oe)
      else $error("pin driven while channel disabled");

   c_cont_pulse: cover property (st_ff.ph == PH_CONT && compare_output_pin ##[1:1000] !compare_output_pin);
   c_pwm_reload: cover property (st_ff.ph == PH_PWM && wrp && st_ff.sec != st_ff.pri);
   c_fault_exit: cover property (st_ff.ph == PH_FAULT ##[1:1000] st_ff.ph == PH_PWM);

endmodule

// [test/cpc_load_model.sv]
// Pin-side partner: load with pull-down and fault signalling source
module cpc_load_model (
   // Bench commands
   input wire logic fault_req_a,
   input wire logic fault_req_b,
   // Channel pins
   input wire logic compare_output_pin,
   input wire logic compare_output_pin_oe,
   output logic fault_input_a,
   output logic fault_input_b,
   output logic pin_level
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----
   // Fault lines are active low and idle high
   // ----
   assign fault_input_a = ~fault_req_a;
   assign fault_input_b = ~fault_req_b;
   // Pull-down gives a safe low while the pin floats in shutdown
   assign pin_level = compare_output_pin_oe ? compare_output_pin : 1'b0;
endmodule

// [test/test_cpc_channel.sv]
// Register-level testbench of the compare pulse and PWM channel
module test_cpc_channel;
   timeunit 1ns;
   timeprecision 100ps;
   import cpc_pkg::*;
   // ----
   // Signals
   // ----
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic fault_req_a = 1'b0, fault_req_b = 1'b0;
   logic fault_input_a, fault_input_b, compare_output_pin, compare_output_pin_oe;
   logic channel_event_flag, pin_level;
   int failures = 0;
   int checks = 0;
   int cycles = 0;
   logic [31:0] duty_v [4] = '{32'h0, 32'h4, 32'h9, 32'hc};
   int high_v [4] = '{0, 40, 90, 100};

   always #2 sys_clk = ~sys_clk;

   cpc_channel #(.CHANNEL_NUM(1)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .fault_input_a(fault_input_a), .fault_input_b(fault_input_b),
      .compare_output_pin(compare_output_pin), .compare_output_pin_oe(compare_output_pin_oe),
      .channel_event_flag(channel_event_flag));

   cpc_load_model load_u (.fault_req_a(fault_req_a), .fault_req_b(fault_req_b),
      .compare_output_pin(compare_output_pin), .compare_output_pin_oe(compare_output_pin_oe),
      .fault_input_a(fault_input_a), .fault_input_b(fault_input_b), .pin_level(pin_level));

   // ----
   // Helpers
   // ----
   task automatic report_and_stop();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, seen, exp);
      end
   endtask

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, rsp);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, d);
      chk(s_axi_rresp, rsp);
   endtask

   // Any 100-clock window holds whole periods of 5, 10 or 20 clocks
   task automatic meas(input int exp);
      int h;
      h = 0;
      repeat (100) begin
         @(negedge sys_clk);
         if (pin_level === 1'b1) h++;
      end
      chk(h, exp);
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 10000) begin
         failures++;
         report_and_stop();
      end
   end

   // ----
   // Tests
   // ----
   initial begin
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rd(CPC_CTRL_OFF, CPC_REG_RST, CPC_RESP_OKAY);
      rd(8'h40, 32'h0, CPC_RESP_SLVERR);
      wr(8'h40, 32'h1, CPC_RESP_SLVERR);
      $display("test bus done");
      // Period register not below the trailing compare before starting
      wr(CPC_T0PER_OFF, 32'h9, CPC_RESP_OKAY);
      wr(CPC_PRI_OFF, 32'h3, CPC_RESP_OKAY);
      wr(CPC_SEC_OFF, 32'h6, CPC_RESP_OKAY);
      wr(CPC_CTRL_OFF, 32'h8005, CPC_RESP_OKAY);
      chk({compare_output_pin_oe, pin_level}, 2'b10);
      wr(CPC_T0CTL_OFF, 32'h8000, CPC_RESP_OKAY);
      meas(30);
      wr(CPC_T0CTL_OFF, 32'h0, CPC_RESP_OKAY);
      wr(CPC_FLAG_OFF, 32'h1, CPC_RESP_OKAY);
      rd(CPC_FLAG_OFF, 32'h0, CPC_RESP_OKAY);
      wr(CPC_T0CTL_OFF, 32'h8000, CPC_RESP_OKAY);
      repeat (16) @(posedge sys_clk);
      chk(channel_event_flag, 1'b1);
      $display("test pulse train done");
      // Time base halted so no period match reloads the duty during the checks
      wr(CPC_T0CTL_OFF, 32'h0, CPC_RESP_OKAY);
      wr(CPC_PRI_OFF, 32'h4, CPC_RESP_OKAY);
      wr(CPC_CTRL_OFF, 32'h8006, CPC_RESP_OKAY);
      rd(CPC_PRI_OFF, 32'h4, CPC_RESP_OKAY);
      wr(CPC_PRI_OFF, 32'h7, CPC_RESP_OKAY);
      rd(CPC_PRI_OFF, 32'h4, CPC_RESP_OKAY);
      wr(CPC_T0CTL_OFF, 32'h8000, CPC_RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         wr(CPC_SEC_OFF, duty_v[i], CPC_RESP_OKAY);
         repeat (25) @(posedge sys_clk);
         meas(high_v[i]);
      end
      rd(CPC_PRI_OFF, 32'hc, CPC_RESP_OKAY);
      wr(CPC_SEC_OFF, 32'h4, CPC_RESP_OKAY);
      wr(CPC_T0CTL_OFF, 32'h8010, CPC_RESP_OKAY);
      repeat (45) @(posedge sys_clk);
      meas(40);
      wr(CPC_T0CTL_OFF, 32'h8000, CPC_RESP_OKAY);
      wr(CPC_SEC_OFF, 32'h00010004, CPC_RESP_OKAY);
      repeat (25) @(posedge sys_clk);
      meas(40);
      $display("test pwm done");
      wr(CPC_T1PER_OFF, 32'h4, CPC_RESP_OKAY);
      wr(CPC_T1CTL_OFF, 32'h8000, CPC_RESP_OKAY);
      wr(CPC_SEC_OFF, 32'h2, CPC_RESP_OKAY);
      wr(CPC_CTRL_OFF, 32'h800e, CPC_RESP_OKAY);
      fault_req_a <= 1'b1;
      repeat (25) @(posedge sys_clk);
      meas(40);
      fault_req_a <= 1'b0;
      wr(CPC_SEC_OFF, 32'h00010002, CPC_RESP_OKAY);
      wr(CPC_CTRL_OFF, 32'h802e, CPC_RESP_OKAY);
      repeat (25) @(posedge sys_clk);
      meas(100);
      $display("test source and width done");
      wr(CPC_CTRL_OFF, 32'h800f, CPC_RESP_OKAY);
      fault_req_b <= 1'b1;
      repeat (5) @(posedge sys_clk);
      chk(compare_output_pin_oe, 1'b1);
      fault_req_b <= 1'b0;
      fault_req_a <= 1'b1;
      #1;
      chk(compare_output_pin_oe, 1'b0);
      repeat (5) @(posedge sys_clk);
      rd(CPC_CTRL_OFF, 32'h801f, CPC_RESP_OKAY);
      chk(channel_event_flag, 1'b1);
      // Fault event serviced while the fault still stands
      wr(CPC_FLAG_OFF, 32'h1, CPC_RESP_OKAY);
      fault_req_a <= 1'b0;
      repeat (5) @(posedge sys_clk);
      chk(compare_output_pin_oe, 1'b0);
      wr(CPC_CTRL_OFF, 32'h800f, CPC_RESP_OKAY);
      repeat (2) @(posedge sys_clk);
      rd(CPC_CTRL_OFF, 32'h800f, CPC_RESP_OKAY);
      chk(compare_output_pin_oe, 1'b1);
      wr(CPC_CTRL_OFF, 32'h0007, CPC_RESP_OKAY);
      repeat (2) @(posedge sys_clk);
      chk(compare_output_pin_oe, 1'b0);
      $display("test fault done");
      report_and_stop();
   end
endmodule
